/* urcs_defs.vh */
/*
 * constants for the uart receive channel setup block: register offsets,
 * field positions, encodings, reset values and status bit positions.
 * assumes it is included once per compile unit by its bare name.
 */
`ifndef URCS_DEFS_VH
`define URCS_DEFS_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define URCS_OFF_PAIR_MODE 8'h00
`define URCS_OFF_SETUP 8'h04
`define URCS_OFF_BAUD 8'h08
`define URCS_OFF_STATUS 8'h0C
`define URCS_OFF_MASK 8'h10
`define URCS_OFF_DATA 8'h14

// ----------------------------------------------------------------------
// paired channel mode register fields
// ----------------------------------------------------------------------
`define URCS_PM_IRQ_SRC 0
`define URCS_PM_MODE_LO 1
`define URCS_PM_CLK_SEL 14
`define URCS_PM_PRESC_SEL 15
`define URCS_MODE_UART 2'h1
`define URCS_PAIR_MODE_RST 16'h0022

// ----------------------------------------------------------------------
// setup register fields and encodings
// ----------------------------------------------------------------------
`define URCS_SU_DIR 7
`define URCS_SU_ERR_EN 10
`define URCS_LEN_9 2'h1
`define URCS_LEN_7 2'h2
`define URCS_LEN_8 2'h3
`define URCS_STOP_ONE 2'h1
`define URCS_PAR_NONE 2'h0
`define URCS_PAR_ZERO 2'h1
`define URCS_PAR_EVEN 2'h2
`define URCS_PAR_ODD 2'h3
`define URCS_SETUP_RST 16'h4097

// ----------------------------------------------------------------------
// status bits and baud divider
// ----------------------------------------------------------------------
`define URCS_ST_DONE 0
`define URCS_ST_ERR 1
`define URCS_ST_FRAME 2
`define URCS_ST_PARITY 3
`define URCS_ST_OVERRUN 4
`define URCS_BAUD_RST 16'h0010

`endif

/* urcs_rx.v */
/*
 * uart receive channel with its setup registers, a two-way prescaler
 * choice, sticky status with mask and one level interrupt.
 * assumes a simple strobe register port on SYS_CLK_I and an idle-high
 * receive line from a remote transmitter, asynchronous to the clock.
 */
`timescale 1ns/10ps
`include "urcs_defs.vh"

module urcs_rx #(
    parameter PRESC_A = 16'h0001,
    parameter PRESC_B = 16'h0004
) (
    input wire SYS_CLK_I,
    input wire RESET_N_I,
    input wire [7:0] ADDR_I,
    input wire [15:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire RXD_I,
    output reg [15:0] RDATA_O,
    output reg IRQ_O,
    output reg RX_DONE_IRQ_O,
    output reg RX_ERROR_IRQ_O
);

// ----------------------------------------------------------------------
// registers
// ----------------------------------------------------------------------
reg [15:0] pair_mode_ff;
reg [15:0] setup_ff;
reg [15:0] baud_ff;
reg [4:0] status_ff;
reg [4:0] mask_ff;
reg [8:0] data_ff;
reg data_full_ff;
reg rxd_s1_ff;
reg rxd_s2_ff;
reg rxd_s3_ff;
reg [15:0] presc_cnt_ff;
reg [15:0] baud_cnt_ff;
reg [1:0] state_ff;
reg [3:0] bit_cnt_ff;
reg [8:0] shift_ff;
reg par_ff;
reg [4:0] nxt_status;

localparam ST_IDLE = 2'd0;
localparam ST_START = 2'd1;
localparam ST_DATA = 2'd2;
localparam ST_TAIL = 2'd3;

wire [4:0] irq_events;
reg ev_done;
reg ev_err;
reg ev_frame;
reg ev_par;
reg ev_ovr;

// ----------------------------------------------------------------------
// helpers
// ----------------------------------------------------------------------
function [3:0] word_bits;
    input [1:0] len;
    begin
        case (len)
            `URCS_LEN_9: word_bits = 4'd9;
            `URCS_LEN_7: word_bits = 4'd7;
            default: word_bits = 4'd8;
        endcase
    end
endfunction

wire [1:0] op_mode = pair_mode_ff[`URCS_PM_MODE_LO+1:`URCS_PM_MODE_LO];
// uart only runs in uart mode with the divided op clock chosen
wire enabled = (op_mode == `URCS_MODE_UART)
    && !pair_mode_ff[`URCS_PM_CLK_SEL]
    && (setup_ff[15:14] == 2'b01);
wire [15:0] presc_div = pair_mode_ff[`URCS_PM_PRESC_SEL] ? PRESC_B
    : PRESC_A;
wire presc_tick = (presc_cnt_ff == 16'h0000);
wire [15:0] half_baud = {1'b0, baud_ff[15:1]};
wire baud_tick = presc_tick && (baud_cnt_ff == 16'h0000);
wire [3:0] nbits = word_bits(setup_ff[1:0]);
wire [1:0] par_mode = setup_ff[9:8];
wire lsb_first = setup_ff[`URCS_SU_DIR];
wire err_en = setup_ff[`URCS_SU_ERR_EN];
// transfer-end source is the only one supported; bit 0 set gives no done or error event
wire src_ok = !pair_mode_ff[`URCS_PM_IRQ_SRC];

// ----------------------------------------------------------------------
// input synchroniser and timing
// ----------------------------------------------------------------------
always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
        rxd_s1_ff <= 1'b1;
        rxd_s2_ff <= 1'b1;
        rxd_s3_ff <= 1'b1;
        presc_cnt_ff <= 16'h0000;
    end else begin
        rxd_s1_ff <= RXD_I;
        rxd_s2_ff <= rxd_s1_ff;
        rxd_s3_ff <= rxd_s2_ff;
        if (presc_tick) begin
            presc_cnt_ff <= presc_div - 16'h0001;
        end else begin
            presc_cnt_ff <= presc_cnt_ff - 16'h0001;
        end
    end
end

// ----------------------------------------------------------------------
// receive state machine
// ----------------------------------------------------------------------
always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
        state_ff <= ST_IDLE;
        bit_cnt_ff <= 4'h0;
        shift_ff <= 9'h000;
        par_ff <= 1'b0;
        baud_cnt_ff <= 16'h0000;
        data_ff <= 9'h000;
        data_full_ff <= 1'b0;
        ev_done <= 1'b0;
        ev_err <= 1'b0;
        ev_frame <= 1'b0;
        ev_par <= 1'b0;
        ev_ovr <= 1'b0;
    end else begin
        ev_done <= 1'b0;
        ev_err <= 1'b0;
        ev_frame <= 1'b0;
        ev_par <= 1'b0;
        ev_ovr <= 1'b0;
        // reading the data word frees the buffer for the next frame
        if (RD_I && ADDR_I == `URCS_OFF_DATA) begin
            data_full_ff <= 1'b0;
        end
        if (presc_tick && baud_cnt_ff != 16'h0000) begin
            baud_cnt_ff <= baud_cnt_ff - 16'h0001;
        end
        case (state_ff)
            ST_IDLE: begin
                if (enabled && rxd_s3_ff && !rxd_s2_ff) begin
                    state_ff <= ST_START;
                    baud_cnt_ff <= half_baud;
                end
            end
            ST_START: begin
                if (baud_tick) begin
                    // a start bit gone high by mid-bit was a glitch
                    state_ff <= rxd_s2_ff ? ST_IDLE : ST_DATA;
                    baud_cnt_ff <= baud_ff;
                    bit_cnt_ff <= 4'h0;
                    shift_ff <= 9'h000;
                    par_ff <= 1'b0;
                end
            end
            ST_DATA: begin
                if (baud_tick) begin
                    baud_cnt_ff <= baud_ff;
                    par_ff <= par_ff ^ rxd_s2_ff;
                    if (lsb_first) begin
                        shift_ff[bit_cnt_ff] <= rxd_s2_ff;
                    end else begin
                        shift_ff <= {shift_ff[7:0], rxd_s2_ff};
                    end
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    if (bit_cnt_ff == nbits - 4'h1) begin
                        state_ff <= ST_TAIL;
                        bit_cnt_ff <= 4'h0;
                    end
                end
            end
            ST_TAIL: begin
                if (baud_tick) begin
                    baud_cnt_ff <= baud_ff;
                    if (par_mode != `URCS_PAR_NONE && bit_cnt_ff == 4'h0) begin
                        bit_cnt_ff <= 4'h1;
                        // zero parity: bit is consumed, never checked
                        if (par_mode == `URCS_PAR_EVEN) begin
                            ev_par <= par_ff ^ rxd_s2_ff;
                        end else if (par_mode == `URCS_PAR_ODD) begin
                            ev_par <= ~(par_ff ^ rxd_s2_ff);
                        end
                    end else begin
                        // only one stop bit is checked
                        state_ff <= ST_IDLE;
                        data_ff <= shift_ff;
                        data_full_ff <= 1'b1;
                        ev_frame <= !rxd_s2_ff;
                        ev_ovr <= data_full_ff;
                        ev_done <= 1'b1;
                    end
                end
            end
            default: state_ff <= ST_IDLE;
        endcase
    end
end

// ----------------------------------------------------------------------
// interrupt routing: error frames go to the error line when enabled
// ----------------------------------------------------------------------
reg par_seen_ff;
always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
        par_seen_ff <= 1'b0;
    end else if (ev_done) begin
        par_seen_ff <= 1'b0;
    end else if (ev_par) begin
        par_seen_ff <= 1'b1;
    end
end
wire frame_err = par_seen_ff | ev_frame | ev_ovr;
wire fire_err = ev_done && frame_err && err_en && src_ok;
wire fire_done = ev_done && !(frame_err && err_en) && src_ok;

assign irq_events = {ev_ovr, ev_par, ev_frame, fire_err, fire_done};

// ----------------------------------------------------------------------
// register port and status
// ----------------------------------------------------------------------
always @* begin
    nxt_status = status_ff;
    if (WR_I && ADDR_I == `URCS_OFF_STATUS) begin
        nxt_status = status_ff & ~WDATA_I[4:0];
    end
    // a new event wins over a clear in the same cycle
    nxt_status = nxt_status | irq_events;
end

always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
        pair_mode_ff <= `URCS_PAIR_MODE_RST;
        setup_ff <= `URCS_SETUP_RST;
        baud_ff <= `URCS_BAUD_RST;
        status_ff <= 5'h00;
        mask_ff <= 5'h00;
        RDATA_O <= 16'h0000;
        IRQ_O <= 1'b0;
        RX_DONE_IRQ_O <= 1'b0;
        RX_ERROR_IRQ_O <= 1'b0;
    end else begin
        status_ff <= nxt_status;
        IRQ_O <= |(nxt_status & mask_ff);
        RX_DONE_IRQ_O <= fire_done;
        RX_ERROR_IRQ_O <= fire_err;
        if (WR_I) begin
            if (ADDR_I == `URCS_OFF_PAIR_MODE) begin
                pair_mode_ff <= WDATA_I;
            end else if (ADDR_I == `URCS_OFF_SETUP) begin
                setup_ff <= WDATA_I;
            end else if (ADDR_I == `URCS_OFF_BAUD) begin
                baud_ff <= WDATA_I;
            end else if (ADDR_I == `URCS_OFF_MASK) begin
                mask_ff <= WDATA_I[4:0];
            end
        end
        RDATA_O <= 16'h0000;
        if (RD_I) begin
            if (ADDR_I == `URCS_OFF_PAIR_MODE) begin
                RDATA_O <= pair_mode_ff;
            end else if (ADDR_I == `URCS_OFF_SETUP) begin
                RDATA_O <= setup_ff;
            end else if (ADDR_I == `URCS_OFF_BAUD) begin
                RDATA_O <= baud_ff;
            end else if (ADDR_I == `URCS_OFF_STATUS) begin
                RDATA_O <= {11'h000, status_ff};
            end else if (ADDR_I == `URCS_OFF_MASK) begin
                RDATA_O <= {11'h000, mask_ff};
            end else if (ADDR_I == `URCS_OFF_DATA) begin
                RDATA_O <= {7'h00, data_ff};
            end
        end
    end
end

endmodule

/* urcs_rx_assertions.sv */
/* port checker for urcs_rx.
   assumes it is bound to every urcs_rx and sees only its ports. */
`timescale 1ns/10ps
module urcs_rx_assertions (
    input wire SYS_CLK_I,
    input wire RESET_N_I,
    input wire [7:0] ADDR_I,
    input wire [15:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire RXD_I,
    input wire [15:0] RDATA_O,
    input wire IRQ_O,
    input wire RX_DONE_IRQ_O,
    input wire RX_ERROR_IRQ_O
);
    // ----------------------------------------------------------------
    // shadow of the few register bits the checks depend on
    // ----------------------------------------------------------------
    reg eoc_ff, src_ff, mode_ok_ff, low_ff;
    reg [4:0] mask_ff;
    wire pulse = RX_DONE_IRQ_O | RX_ERROR_IRQ_O;
    always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            eoc_ff <= 1'b0;
            src_ff <= 1'b0;
            mode_ok_ff <= 1'b1;
            low_ff <= 1'b0;
            mask_ff <= 5'h00;
        end else begin
            // a start bit must have been seen since the last completion
            low_ff <= !RXD_I | (low_ff & !pulse);
            if (WR_I && ADDR_I == 8'h04) eoc_ff <= WDATA_I[10];
            if (WR_I && ADDR_I == 8'h10) mask_ff <= WDATA_I[4:0];
            if (WR_I && ADDR_I == 8'h00) begin
                src_ff <= WDATA_I[0];
                mode_ok_ff <= WDATA_I[2:1] == 2'h1 && !WDATA_I[14];
            end
        end
    end
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    a_pulse_excl: assert property (!(RX_DONE_IRQ_O && RX_ERROR_IRQ_O))
        else $error("done and error pulses together");
    a_done_single: assert property (RX_DONE_IRQ_O |=> !RX_DONE_IRQ_O)
        else $error("done pulse longer than one cycle");
    a_err_single: assert property (RX_ERROR_IRQ_O |=> !RX_ERROR_IRQ_O)
        else $error("error pulse longer than one cycle");
    a_err_needs_eoc: assert property (RX_ERROR_IRQ_O |-> eoc_ff)
        else $error("error pulse while error irq disabled");
    a_frame_start: assert property (pulse |-> low_ff)
        else $error("completion without a start bit");
    a_src_end: assert property (pulse |-> !src_ff)
        else $error("pulse with other irq source");
    a_mode_gate: assert property (pulse |-> mode_ok_ff)
        else $error("pulse outside uart mode");
    a_irq_follow: assert property
        ((RX_DONE_IRQ_O && mask_ff[0]) |-> ##[0:3] IRQ_O)
        else $error("unmasked done gave no irq");
    a_irq_cause: assert property ($rose(IRQ_O) |-> mask_ff != 5'h00)
        else $error("irq rose with all masked");
    c_err: cover property (RX_ERROR_IRQ_O);
    c_done_irq: cover property (RX_DONE_IRQ_O && mask_ff[0]);
    c_irq: cover property ($rose(IRQ_O));
endmodule
bind urcs_rx urcs_rx_assertions urcs_rx_assertions_inst (
    .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RXD_I(RXD_I),
    .RDATA_O(RDATA_O), .IRQ_O(IRQ_O), .RX_DONE_IRQ_O(RX_DONE_IRQ_O),
    .RX_ERROR_IRQ_O(RX_ERROR_IRQ_O));

/* urcs_rx_bench.sv */
/* self-checking bench for urcs_rx through its register port.
   assumes urcs_tx_model drives the receive line. */
`timescale 1ns/10ps
module urcs_rx_bench;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [15:0] wd = 16'h0000;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [15:0] v;
    reg [4:0] msk = 5'h00;
    wire rxd, irq, dn, er;
    wire [15:0] rdata;
    int err_total = 0, compares = 0, cyc = 0, ndn = 0, ner = 0, bt = 4;
    always #4 clk = ~clk;
    urcs_rx urcs_rx_inst (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr),
        .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RXD_I(rxd), .RDATA_O(rdata),
        .IRQ_O(irq), .RX_DONE_IRQ_O(dn), .RX_ERROR_IRQ_O(er));
    urcs_tx_model urcs_tx_model_inst (.clk_i(clk), .rxd_o(rxd));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task give_verdict;
        $display("mismatches %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        ndn <= ndn + dn;
        ner <= ner + er;
        // a whole run needs well under a tenth of this
        if (cyc == 60000) begin
            err_total++;
            give_verdict;
        end
    end
    task chk(input [15:0] s, input [15:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, s, e);
        end
    endtask
    task wr_reg(input [7:0] a, input [15:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input [7:0] a, output [15:0] q);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 q = rdata;
    endtask
    // rdm: 0 leaves data unread, 1 reads and compares, 2 only reads
    task frame(input [15:0] su, input [8:0] d, input bit bad, input bit stp,
               input [15:0] st, input [1:0] rdm);
        int b, k, n;
        b = ndn + ner;
        n = (su[1:0] == 2'h1) ? 9 : (su[1:0] == 2'h2) ? 7 : 8;
        wr_reg(8'h04, su);
        urcs_tx_model_inst.send(d, n, su[7], su[9:8], bad, stp, bt);
        k = 0;
        while (ndn + ner == b && k < 40) begin
            @(posedge clk);
            k++;
        end
        repeat (4) @(posedge clk);
        chk(16'(ndn + ner - b), {15'h0, st[0] | st[1]});
        rd_reg(8'h0C, v);
        chk(v, st);
        chk({15'h0, irq}, {15'h0, |(st[4:0] & msk)});
        if (rdm != 2'h0) rd_reg(8'h14, v);
        if (rdm == 2'h1) chk(v, {7'h00, d});
        wr_reg(8'h0C, 16'h001F);
        repeat (3) @(posedge clk);
        chk({15'h0, irq}, 16'h0000);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(8'h00, v);
        chk(v, 16'h0022);
        rd_reg(8'h04, v);
        chk(v, 16'h4097);
        rd_reg(8'h1C, v);
        chk(v, 16'h0000);
        wr_reg(8'h08, 16'h0003);
        frame(16'h4097, 9'h0A5, 0, 1, 16'h0001, 1);
        frame(16'h4216, 9'h05B, 0, 1, 16'h0001, 1);
        wr_reg(8'h10, 16'h001F);
        msk = 5'h1F;
        frame(16'h4395, 9'h1C3, 0, 1, 16'h0001, 1);
        frame(16'h4117, 9'h0E1, 1, 1, 16'h0001, 1);
        frame(16'h4217, 9'h033, 1, 1, 16'h0009, 2);
        frame(16'h4617, 9'h033, 1, 1, 16'h000A, 2);
        frame(16'h4417, 9'h07E, 0, 0, 16'h0006, 2);
        frame(16'h4097, 9'h03C, 0, 1, 16'h0001, 0);
        frame(16'h4097, 9'h0C3, 0, 1, 16'h0011, 2);
        wr_reg(8'h00, 16'h8022);
        bt = 16;
        frame(16'h4097, 9'h069, 0, 1, 16'h0001, 1);
        wr_reg(8'h00, 16'h0020);
        frame(16'h4097, 9'h055, 0, 1, 16'h0000, 0);
        give_verdict;
    end
endmodule

/* urcs_tx_model.sv */
/* remote asynchronous transmitter driving the receive line.
   assumes the caller gives bit time in clock cycles; idles high. */
`timescale 1ns/10ps
module urcs_tx_model (
    input wire clk_i,
    output reg rxd_o
);
    initial rxd_o = 1'b1;
    task put(input bit v, input int cyc);
        rxd_o <= v;
        repeat (cyc) @(posedge clk_i);
    endtask
    // bad flips the parity slot, stp is the stop level sent
    task send(input [8:0] d, input int n, input bit lsb, input [1:0] par,
              input bit bad, input bit stp, input int cyc);
        int i;
        reg p;
        p = ((par == 2'h3) ? ~^d : (par == 2'h2) ? ^d : 1'b0) ^ bad;
        put(1'b0, cyc);
        for (i = 0; i < n; i++) begin
            put(lsb ? d[i] : d[n - 1 - i], cyc);
        end
        if (par != 2'h0) put(p, cyc);
        put(stp, cyc);
        rxd_o <= 1'b1;
    endtask
endmodule
